// file: ptu_top.sv
`timescale 1ns/1ns
module ptu_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // linear address request
    input  wire logic        req_valid,
    input  wire logic [31:0] req_lin_addr,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_cpl,
    input  wire logic        req_desc,
    output logic             req_ready,
    // translation result
    output logic             phys_valid,
    output logic [31:0]      phys_addr,
    output logic             fault_valid,
    output logic [7:0]       fault_vector,
    output logic [15:0]      fault_error_code,
    // memory bus for table walks
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic             mem_write,
    output logic [31:0]      mem_wdata,
    output logic             mem_lock,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    // control register moves
    input  wire logic        cr_wr_en,
    input  wire logic [1:0]  cr_sel,
    input  wire logic [31:0] cr_wdata,
    output logic [31:0]      page_fault_address,
    output logic [31:0]      page_directory_base
);
    ptu_pkg::ptu_state_t s_reg;
    ptu_pkg::ptu_state_t s_next;
    ptu_tlb_if           tif ();

    logic        pdb_wr;
    logic [31:0] pte_new;
    logic        viol_walk;
    logic        viol_hit;

    ptu_tlb u_tlb (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tif   (tif)
    );

    // protection check shared by hit path and walk path
    function automatic logic prot_viol(input logic usr, input logic wr,
                                       input logic us_bit, input logic rw_bit);
        return usr && (!us_bit || (wr && !rw_bit));
    endfunction

    function automatic logic [15:0] err_code(input logic prot, input logic wr,
                                             input logic usr);
        logic [15:0] c;
        c = 16'h0000;
        c[ptu_pkg::ERR_P]  = prot;
        c[ptu_pkg::ERR_WR] = wr;
        c[ptu_pkg::ERR_US] = usr;
        return c;
    endfunction

    assign pdb_wr = cr_wr_en && (cr_sel == ptu_pkg::CR_SEL_PDB);

    assign tif.addr       = s_reg.lin;
    assign tif.fill       = s_reg.fill;
    assign tif.fill_frame = s_reg.pte[31:ptu_pkg::OFF_W];
    assign tif.fill_us    = s_reg.eff_us;
    assign tif.fill_rw    = s_reg.eff_rw;
    assign tif.fill_dirty = s_reg.pte[ptu_pkg::BIT_D];
    assign tif.flush      = pdb_wr;

    // combined attributes: the lower of each bit pair wins
    assign viol_walk = prot_viol(s_reg.usr, s_reg.wr,
                                 s_reg.pde[ptu_pkg::BIT_US] & mem_rdata[ptu_pkg::BIT_US],
                                 s_reg.pde[ptu_pkg::BIT_RW] & mem_rdata[ptu_pkg::BIT_RW]);
    assign viol_hit  = prot_viol(s_reg.usr, s_reg.wr, tif.hit_us, tif.hit_rw);

    always_comb begin
        pte_new = mem_rdata;
        pte_new[ptu_pkg::BIT_A] = 1'b1;
        if (s_reg.wr) begin
            pte_new[ptu_pkg::BIT_D] = 1'b1;
        end
    end

    always_comb begin
        s_next             = s_reg;
        s_next.phys_valid  = 1'b0;
        s_next.fault_valid = 1'b0;
        s_next.fill        = 1'b0;

        // software moves to the control registers
        if (pdb_wr) begin
            s_next.pdb = {cr_wdata[31:ptu_pkg::OFF_W], ptu_pkg::PDB_LOW};
        end
        if (cr_wr_en && (cr_sel == ptu_pkg::CR_SEL_PFA)) begin
            s_next.pfa = cr_wdata;
        end

        unique case (s_reg.st)
            ptu_pkg::ST_IDLE: begin
                if (req_valid) begin
                    s_next.lin       = req_lin_addr;
                    s_next.wr        = req_write;
                    s_next.desc      = req_desc;
                    // descriptor table walks count as supervisor
                    s_next.usr       = (req_cpl == ptu_pkg::CPL_USER) && !req_desc;
                    s_next.req_ready = 1'b0;
                    s_next.st        = ptu_pkg::ST_CHECK;
                end
            end
            ptu_pkg::ST_CHECK: begin
                // a clean cached page still walks on a write so dirty gets set
                if (tif.hit && (!s_reg.wr || tif.hit_dirty)) begin
                    if (viol_hit) begin
                        s_next.fault_valid      = 1'b1;
                        s_next.fault_error_code = err_code(1'b1, s_reg.wr, s_reg.usr);
                        s_next.pfa              = s_reg.lin;
                    end else begin
                        s_next.phys_valid = 1'b1;
                        s_next.phys_addr  = {tif.hit_frame,
                                             s_reg.lin[ptu_pkg::OFF_W-1:0]};
                    end
                    s_next.req_ready = 1'b1;
                    s_next.st        = ptu_pkg::ST_IDLE;
                end else begin
                    s_next.mem_req   = 1'b1;
                    s_next.mem_write = 1'b0;
                    s_next.mem_lock  = 1'b1;
                    s_next.mem_addr  = {s_reg.pdb[31:ptu_pkg::OFF_W],
                                        s_reg.lin[31:ptu_pkg::DIR_IDX_LSB], 2'h0};
                    s_next.st        = ptu_pkg::ST_PDE_RD;
                end
            end
            ptu_pkg::ST_PDE_RD: begin
                if (mem_ack) begin
                    s_next.pde = mem_rdata;
                    if (!mem_rdata[ptu_pkg::BIT_P]) begin
                        s_next.mem_req          = 1'b0;
                        s_next.mem_lock         = 1'b0;
                        s_next.fault_valid      = 1'b1;
                        s_next.fault_error_code = err_code(1'b0, s_reg.wr, s_reg.usr);
                        s_next.pfa              = s_reg.lin;
                        s_next.req_ready        = 1'b1;
                        s_next.st               = ptu_pkg::ST_IDLE;
                    end else if (!mem_rdata[ptu_pkg::BIT_A]) begin
                        // write back under the same lock as the read
                        s_next.mem_write                  = 1'b1;
                        s_next.mem_wdata                  = mem_rdata;
                        s_next.mem_wdata[ptu_pkg::BIT_A]  = 1'b1;
                        s_next.st                         = ptu_pkg::ST_PDE_WR;
                    end else begin
                        s_next.mem_write = 1'b0;
                        s_next.mem_addr  = {mem_rdata[31:ptu_pkg::OFF_W],
                                            s_reg.lin[ptu_pkg::DIR_IDX_LSB-1:
                                                      ptu_pkg::TBL_IDX_LSB], 2'h0};
                        s_next.st        = ptu_pkg::ST_PTE_RD;
                    end
                end
            end
            ptu_pkg::ST_PDE_WR: begin
                if (mem_ack) begin
                    s_next.mem_write = 1'b0;
                    s_next.mem_addr  = {s_reg.pde[31:ptu_pkg::OFF_W],
                                        s_reg.lin[ptu_pkg::DIR_IDX_LSB-1:
                                                  ptu_pkg::TBL_IDX_LSB], 2'h0};
                    s_next.st        = ptu_pkg::ST_PTE_RD;
                end
            end
            ptu_pkg::ST_PTE_RD: begin
                if (mem_ack) begin
                    s_next.pte    = pte_new;
                    s_next.eff_us = s_reg.pde[ptu_pkg::BIT_US]
                        & mem_rdata[ptu_pkg::BIT_US];
                    s_next.eff_rw = s_reg.pde[ptu_pkg::BIT_RW]
                        & mem_rdata[ptu_pkg::BIT_RW];
                    if (!mem_rdata[ptu_pkg::BIT_P] || viol_walk) begin
                        s_next.mem_req          = 1'b0;
                        s_next.mem_lock         = 1'b0;
                        s_next.fault_valid      = 1'b1;
                        s_next.fault_error_code = err_code(mem_rdata[ptu_pkg::BIT_P],
                                                           s_reg.wr, s_reg.usr);
                        s_next.pfa              = s_reg.lin;
                        s_next.req_ready        = 1'b1;
                        s_next.st               = ptu_pkg::ST_IDLE;
                    end else if (pte_new != mem_rdata) begin
                        s_next.mem_write = 1'b1;
                        s_next.mem_wdata = pte_new;
                        s_next.st        = ptu_pkg::ST_PTE_WR;
                    end else begin
                        s_next.mem_req  = 1'b0;
                        s_next.mem_lock = 1'b0;
                        s_next.fill     = 1'b1;
                        s_next.st       = ptu_pkg::ST_FILL;
                    end
                end
            end
            ptu_pkg::ST_PTE_WR: begin
                if (mem_ack) begin
                    s_next.mem_req   = 1'b0;
                    s_next.mem_write = 1'b0;
                    s_next.mem_lock  = 1'b0;
                    s_next.fill      = 1'b1;
                    s_next.st        = ptu_pkg::ST_FILL;
                end
            end
            ptu_pkg::ST_FILL: begin
                s_next.phys_valid = 1'b1;
                s_next.phys_addr  = {s_reg.pte[31:ptu_pkg::OFF_W],
                                     s_reg.lin[ptu_pkg::OFF_W-1:0]};
                s_next.req_ready  = 1'b1;
                s_next.st         = ptu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg              <= '0;
            s_reg.st           <= ptu_pkg::ST_IDLE;
            s_reg.req_ready    <= 1'b1;
            s_reg.fault_vector <= ptu_pkg::PF_VECTOR;
            s_reg.pfa          <= ptu_pkg::PFA_RST;
            s_reg.pdb          <= ptu_pkg::PDB_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready           = s_reg.req_ready;
    assign phys_valid          = s_reg.phys_valid;
    assign phys_addr           = s_reg.phys_addr;
    assign fault_valid         = s_reg.fault_valid;
    assign fault_vector        = s_reg.fault_vector;
    assign fault_error_code    = s_reg.fault_error_code;
    assign mem_req             = s_reg.mem_req;
    assign mem_addr            = s_reg.mem_addr;
    assign mem_write           = s_reg.mem_write;
    assign mem_wdata           = s_reg.mem_wdata;
    assign mem_lock            = s_reg.mem_lock;
    assign page_fault_address  = s_reg.pfa;
    assign page_directory_base = s_reg.pdb;
endmodule

// file: ptu_pkg.sv
package ptu_pkg;
    // address split
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned OFF_W       = 12;
    localparam int unsigned FRAME_W     = 20;
    localparam int unsigned DIR_IDX_LSB = 22;
    localparam int unsigned TBL_IDX_LSB = 12;
    // directory and table entry bits
    localparam int unsigned BIT_P  = 0;
    localparam int unsigned BIT_RW = 1;
    localparam int unsigned BIT_US = 2;
    localparam int unsigned BIT_A  = 5;
    localparam int unsigned BIT_D  = 6;
    // page-fault error code bits
    localparam int unsigned ERR_P  = 0;
    localparam int unsigned ERR_WR = 1;
    localparam int unsigned ERR_US = 2;
    localparam logic [1:0]  CPL_USER  = 2'h3;
    localparam logic [7:0]  PF_VECTOR = 8'h0E;
    // control register selectors
    localparam logic [1:0]  CR_SEL_PFA = 2'h2;
    localparam logic [1:0]  CR_SEL_PDB = 2'h3;
    localparam logic [31:0] PFA_RST    = 32'h0000_0000;
    localparam logic [31:0] PDB_RST    = 32'h0000_0000;
    localparam logic [11:0] PDB_LOW    = 12'h000;
    // lookaside buffer geometry
    localparam int unsigned TLB_WAYS    = 4;
    localparam int unsigned TLB_SETS    = 8;
    localparam int unsigned TLB_ENTRIES = 32;
    localparam int unsigned WAY_W       = 2;
    localparam int unsigned SET_W       = 3;
    localparam int unsigned TAG_W       = 17;
    localparam int unsigned TAG_LSB     = 15;

    typedef struct packed {
        logic                valid;
        logic [TAG_W-1:0]    tag;
        logic [FRAME_W-1:0]  frame;
        logic                usr;
        logic                rw;
        logic                dirty;
    } ptu_tlb_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_PDE_RD,
        ST_PDE_WR,
        ST_PTE_RD,
        ST_PTE_WR,
        ST_FILL
    } ptu_walk_st_t;

    typedef struct packed {
        ptu_walk_st_t        st;
        logic [ADDR_W-1:0]   lin;
        logic                wr;
        logic                usr;
        logic                desc;
        logic [31:0]         pde;
        logic [31:0]         pte;
        logic                eff_us;
        logic                eff_rw;
        logic                req_ready;
        logic                phys_valid;
        logic [ADDR_W-1:0]   phys_addr;
        logic                fault_valid;
        logic [7:0]          fault_vector;
        logic [15:0]         fault_error_code;
        logic                mem_req;
        logic [ADDR_W-1:0]   mem_addr;
        logic                mem_write;
        logic [31:0]         mem_wdata;
        logic                mem_lock;
        logic [ADDR_W-1:0]   pfa;
        logic [ADDR_W-1:0]   pdb;
        logic                fill;
    } ptu_state_t;
endpackage

// file: ptu_tlb_if.sv
`timescale 1ns/1ns
interface ptu_tlb_if;
    logic [31:0] addr;
    logic        hit;
    logic [19:0] hit_frame;
    logic        hit_us;
    logic        hit_rw;
    logic        hit_dirty;
    logic        fill;
    logic [19:0] fill_frame;
    logic        fill_us;
    logic        fill_rw;
    logic        fill_dirty;
    logic        flush;

    modport walker (
        output addr, fill, fill_frame, fill_us, fill_rw, fill_dirty, flush,
        input  hit, hit_frame, hit_us, hit_rw, hit_dirty
    );
    modport cache (
        input  addr, fill, fill_frame, fill_us, fill_rw, fill_dirty, flush,
        output hit, hit_frame, hit_us, hit_rw, hit_dirty
    );
endinterface

// file: ptu_tlb.sv
`timescale 1ns/1ns
module ptu_tlb (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // walker side
    ptu_tlb_if.cache tif
);
    typedef struct packed {
        ptu_pkg::ptu_tlb_entry_t [ptu_pkg::TLB_ENTRIES-1:0] ent;
        logic [ptu_pkg::TLB_SETS-1:0][ptu_pkg::WAY_W-1:0]   victim;
    } ptu_tlb_state_t;

    ptu_tlb_state_t s_reg;
    ptu_tlb_state_t s_next;
    logic [ptu_pkg::TLB_WAYS-1:0] way_hit;

    function automatic logic [ptu_pkg::SET_W-1:0] set_of(input logic [31:0] a);
        return a[ptu_pkg::TBL_IDX_LSB +: ptu_pkg::SET_W];
    endfunction

    function automatic logic [ptu_pkg::TAG_W-1:0] tag_of(input logic [31:0] a);
        return a[ptu_pkg::TAG_LSB +: ptu_pkg::TAG_W];
    endfunction

    // upper 20 bits split into set index and tag, compared in all ways
    genvar w;
    generate
        for (w = 0; w < ptu_pkg::TLB_WAYS; w++) begin : g_way
            ptu_pkg::ptu_tlb_entry_t e;
            assign e = s_reg.ent[{set_of(tif.addr), 2'(w)}];
            assign way_hit[w] = e.valid && (e.tag == tag_of(tif.addr));
        end
    endgenerate

    always_comb begin
        ptu_pkg::ptu_tlb_entry_t e;
        e = '0;
        for (int i = 0; i < ptu_pkg::TLB_WAYS; i++) begin
            if (way_hit[i]) begin
                e = s_reg.ent[{set_of(tif.addr), 2'(i)}];
            end
        end
        tif.hit       = |way_hit;
        tif.hit_frame = e.frame;
        tif.hit_us    = e.usr;
        tif.hit_rw    = e.rw;
        tif.hit_dirty = e.dirty;
    end

    always_comb begin
        logic [ptu_pkg::WAY_W-1:0] way;
        logic [ptu_pkg::SET_W-1:0] set;
        way = s_reg.victim[set_of(tif.addr)];
        set = set_of(tif.addr);
        s_next = s_reg;
        for (int i = 0; i < ptu_pkg::TLB_WAYS; i++) begin
            if (way_hit[i]) begin
                way = 2'(i);
            end
        end
        if (tif.flush) begin
            // flush beats a fill in the same cycle: the fill may be stale
            for (int i = 0; i < ptu_pkg::TLB_ENTRIES; i++) begin
                s_next.ent[i].valid = 1'b0;
            end
        end else if (tif.fill) begin
            s_next.ent[{set, way}] = '{valid: 1'b1, tag: tag_of(tif.addr),
                                       frame: tif.fill_frame, usr: tif.fill_us,
                                       rw: tif.fill_rw, dirty: tif.fill_dirty};
            if (!(|way_hit)) begin
                s_next.victim[set] = s_reg.victim[set] + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// file: ptu_top_asserts.sv
`timescale 1ns/1ns
module ptu_top_asserts (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // request and result
    input wire logic        req_valid,
    input wire logic [31:0] req_lin_addr,
    input wire logic        req_write,
    input wire logic        req_ready,
    input wire logic        phys_valid,
    input wire logic [31:0] phys_addr,
    input wire logic        fault_valid,
    input wire logic [7:0]  fault_vector,
    input wire logic [15:0] fault_error_code,
    // memory bus
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_write,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_lock,
    input wire logic        mem_ack,
    // registers
    input wire logic [31:0] page_fault_address,
    input wire logic [31:0] page_directory_base
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [31:0] lin_q;
    logic        wr_q;
    // remembers the request in flight so results can be tied to it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lin_q <= 32'h0000_0000;
            wr_q  <= 1'b0;
        end else if (req_valid && req_ready) begin
            lin_q <= req_lin_addr;
            wr_q  <= req_write;
        end
    end
    a_take_drops_ready: assert property (req_valid && req_ready |=> !req_ready)
        else $error("ready still high after a request was taken");
    a_result_bound: assert property (req_valid && req_ready |->
        ##[2:120] (phys_valid || fault_valid)) else $error("no result after a request");
    a_result_once: assert property ((phys_valid || fault_valid) |-> req_ready ##1
        !(phys_valid || fault_valid)) else $error("result not a single pulse with ready");
    a_phys_offset: assert property (phys_valid |-> phys_addr[11:0] == lin_q[11:0])
        else $error("page offset not carried through");
    a_fault_vector: assert property (fault_valid |-> fault_vector == 8'h0E)
        else $error("fault vector wrong");
    a_fault_addr: assert property (fault_valid |-> ##[0:1] page_fault_address == lin_q)
        else $error("fault address not loaded");
    a_err_layout: assert property (fault_valid |-> fault_error_code[1] == wr_q &&
        fault_error_code[15:3] == 13'h0000) else $error("error code direction or spare bits");
    a_pdb_aligned: assert property (page_directory_base[11:0] == 12'h000)
        else $error("directory base not page aligned");
    a_lock_writes: assert property (mem_req && mem_write |-> mem_lock)
        else $error("entry write-back not locked");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
        $stable(mem_write) && $stable(mem_wdata)) else $error("memory request changed early");
endmodule
bind ptu_top ptu_top_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_lin_addr(req_lin_addr), .req_write(req_write), .req_ready(req_ready),
    .phys_valid(phys_valid), .phys_addr(phys_addr), .fault_valid(fault_valid),
    .fault_vector(fault_vector), .fault_error_code(fault_error_code), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_lock(mem_lock),
    .mem_ack(mem_ack), .page_fault_address(page_fault_address),
    .page_directory_base(page_directory_base));

// file: ptu_mem_model.sv
`timescale 1ns/1ns
module ptu_mem_model (
    // clock
    input wire logic        mclk,
    // bus from the walker
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_write,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_lock,
    output logic [31:0]     mem_rdata,
    output logic            mem_ack,
    // response delay in cycles
    input wire logic [3:0]  wait_cycles
);
    logic [31:0] mem [logic [31:0]];
    logic [3:0]  cnt;
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 32'h0000_0000;
        cnt       = 4'h0;
    end
    // read data toggles except on a read ack so a stale word is never mistaken
    always @(posedge mclk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (cnt >= wait_cycles) begin
                cnt     <= 4'h0;
                mem_ack <= 1'b1;
                if (mem_write)
                    mem[mem_addr] = mem_wdata;
                else
                    mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// file: ptu_top_tb.sv
`timescale 1ns/1ns
module ptu_top_tb;
    typedef struct {
        logic [31:0] lin;
        logic        wr;
        logic [1:0]  cpl;
        logic        desc;
        logic        flt;
        logic [31:0] exp;
    } ptu_row_t;
    logic        mclk, rst_n, req_valid, req_write, req_desc, req_ready;
    logic        phys_valid, fault_valid, mem_req, mem_write, mem_lock, mem_ack;
    logic        cr_wr_en, walked;
    logic [1:0]  req_cpl, cr_sel;
    logic [3:0]  mem_wait;
    logic [7:0]  fault_vector;
    logic [15:0] fault_error_code;
    logic [31:0] req_lin_addr, phys_addr, mem_addr, mem_wdata, mem_rdata, cr_wdata;
    logic [31:0] page_fault_address, page_directory_base;
    logic [31:0] way_lin [4];
    logic [31:0] way_phys [4];
    ptu_row_t    rows [12];
    int          fails, checked, cycles;

    ptu_top DUT (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_lin_addr(req_lin_addr),
        .req_write(req_write), .req_cpl(req_cpl), .req_desc(req_desc), .req_ready(req_ready),
        .phys_valid(phys_valid), .phys_addr(phys_addr), .fault_valid(fault_valid),
        .fault_vector(fault_vector), .fault_error_code(fault_error_code), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata),
        .mem_lock(mem_lock), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cr_wr_en(cr_wr_en),
        .cr_sel(cr_sel), .cr_wdata(cr_wdata), .page_fault_address(page_fault_address),
        .page_directory_base(page_directory_base));
    ptu_mem_model mem_m (.mclk(mclk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_lock(mem_lock),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wait_cycles(mem_wait));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic cr_write(input logic [1:0] sel, input logic [31:0] val);
        @(posedge mclk);
        cr_wr_en <= 1'b1;
        cr_sel   <= sel;
        cr_wdata <= val;
        @(posedge mclk);
        cr_wr_en <= 1'b0;
        @(negedge mclk);
    endtask
    // result is sampled at the falling edge, where the one-cycle pulse stands
    task automatic access(input logic [31:0] a, input logic w, input logic [1:0] c,
                          input logic d, input logic [3:0] wt);
        int n;
        @(posedge mclk);
        req_valid    <= 1'b1;
        req_lin_addr <= a;
        req_write    <= w;
        req_cpl      <= c;
        req_desc     <= d;
        mem_wait     <= wt;
        do begin
            @(posedge mclk);
        end while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        walked = 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            if (mem_req === 1'b1)
                walked = 1'b1;
            n++;
        end while (phys_valid !== 1'b1 && fault_valid !== 1'b1 && n < 200);
        chk("result", 32'h0000_0001, {31'h0, phys_valid | fault_valid});
    endtask

    initial begin
        {rst_n, req_valid, req_write, req_desc, cr_wr_en} = 5'h00;
        {req_cpl, cr_sel, mem_wait} = 8'h00;
        {req_lin_addr, cr_wdata} = 64'h0;
        mem_m.mem[32'h0001_0004] = 32'h0002_0027;
        mem_m.mem[32'h0001_000C] = 32'h0003_0003;
        mem_m.mem[32'h0002_0000] = 32'hAAAA_A067;
        mem_m.mem[32'h0002_0004] = 32'hBBBB_B005;
        mem_m.mem[32'h0002_000C] = 32'hCCCC_C003;
        mem_m.mem[32'h0002_0020] = 32'h1111_1067;
        mem_m.mem[32'h0002_0040] = 32'h2222_2067;
        mem_m.mem[32'h0002_0060] = 32'h3333_3067;
        mem_m.mem[32'h0003_0000] = 32'hDDDD_D067;
        rows = '{'{32'h0040_0123, 0, 3, 0, 0, 32'hAAAA_A123},
                 '{32'h0040_0123, 1, 3, 0, 0, 32'hAAAA_A123},
                 '{32'h0040_1FFF, 0, 3, 0, 0, 32'hBBBB_BFFF},
                 '{32'h0040_1004, 1, 3, 0, 1, 32'h0000_0007},
                 '{32'h0040_1004, 1, 2, 0, 0, 32'hBBBB_B004},
                 '{32'h0040_2000, 0, 0, 0, 1, 32'h0000_0000},
                 '{32'h0080_0000, 1, 3, 0, 1, 32'h0000_0006},
                 '{32'h0040_3010, 0, 3, 0, 1, 32'h0000_0005},
                 '{32'h00C0_0008, 0, 3, 0, 1, 32'h0000_0005},
                 '{32'h00C0_0008, 1, 1, 0, 0, 32'hDDDD_D008},
                 '{32'h0040_3010, 0, 3, 1, 0, 32'hCCCC_C010},
                 '{32'h0080_0000, 0, 3, 1, 1, 32'h0000_0000}};
        way_lin  = '{32'h0040_0123, 32'h0040_8000, 32'h0041_0000, 32'h0041_8000};
        way_phys = '{32'hAAAA_A123, 32'h1111_1000, 32'h2222_2000, 32'h3333_3000};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        cr_write(2'h3, 32'h0001_0FFF);
        chk("page_directory_base", 32'h0001_0000, page_directory_base);
        for (int i = 0; i < 12; i++) begin
            access(rows[i].lin, rows[i].wr, rows[i].cpl, rows[i].desc,
                   {2'h0, i[0], i[0]});
            chk("fault_valid", {31'h0, rows[i].flt}, {31'h0, fault_valid});
            if (rows[i].flt) begin
                chk("fault_error_code", rows[i].exp, {16'h0, fault_error_code});
                chk("page_fault_address", rows[i].lin, page_fault_address);
                chk("fault_vector", 32'h0000_000E, {24'h0, fault_vector});
            end else begin
                chk("phys_addr", rows[i].exp, phys_addr);
            end
        end
        chk("table entry", 32'hBBBB_B065, mem_m.mem[32'h0002_0004]);
        chk("directory entry", 32'h0003_0023, mem_m.mem[32'h0001_000C]);
        cr_write(2'h3, 32'h0001_0000);
        for (int p = 0; p < 2; p++) begin
            for (int j = 0; j < 4; j++) begin
                access(way_lin[j], 1'b0, 2'h3, 1'b0, 4'h0);
                chk("walked", {31'h0, p == 0}, {31'h0, walked});
                chk("phys_addr", way_phys[j], phys_addr);
            end
        end
        cr_write(2'h2, 32'h1234_5678);
        chk("page_fault_address", 32'h1234_5678, page_fault_address);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("reset regs", 32'h0000_0000, page_fault_address | page_directory_base);
        chk("reset ready", 32'h0000_0001, {31'h0, req_ready});
        chk("reset vector", 32'h0000_000E, {24'h0, fault_vector});
        @(posedge mclk);
        rst_n <= 1'b1;
        test_done();
    end
endmodule
